// ===== core/acr_cfg_regs.sv
module acr_cfg_regs #(
    parameter int unsigned MS_CYCLES = acr_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire acr_pkg::acr_wb_req_t wb_i,
    output acr_pkg::acr_wb_rsp_t wb_o,
    // orientation and level detection
    input wire logic updown_i,
    input wire logic [7:0] level_measure_i,
    output logic orient_irq_o,
    output logic level_irq_o,
    output logic level_flat_o,
    output logic [5:0] orient_block_angle_o,
    output logic [5:0] level_angle_o,
    // self-test
    output acr_pkg::acr_st_t st_o
);

    typedef struct packed {
        acr_pkg::acr_cfg_t cfg;
        logic unlock;
        logic ack;
        logic [31:0] rdat;
        logic ud_prev;
        logic orient_irq;
        logic flat;
        logic shown;
        logic [26:0] hold_cnt;
        logic level_irq;
        logic prog_pls;
        logic load_pls;
        logic soft_pls;
    } acr_regs_state_t;

    acr_regs_state_t s_r;
    acr_regs_state_t s_nxt;
    acr_pkg::acr_cfg_t nvm_image;
    logic nvm_done;
    logic nvm_ready;
    logic nvm_loading;
    logic [3:0] nvm_remain;
    logic req;
    logic [7:0] idx;
    logic [26:0] hold_lim;
    logic [8:0] thr;
    logic [8:0] band;

    // hold time in clock cycles for a two-bit code
    function automatic logic [26:0] hold_cycles(input logic [1:0] code);
        logic [26:0] c;
        c = 27'h000_0000;
        unique case (code)
            2'b00: c = 27'h000_0000;
            2'b01: c = 27'(acr_pkg::HOLD_MS_1 * MS_CYCLES);
            2'b10: c = 27'(acr_pkg::HOLD_MS_2 * MS_CYCLES);
            2'b11: c = 27'(acr_pkg::HOLD_MS_3 * MS_CYCLES);
        endcase
        return c;
    endfunction

    // index decode used only by the unmapped-read check
    function automatic logic is_mapped(input logic [7:0] i);
        return (i == acr_pkg::IDX_ORIENT) || (i == acr_pkg::IDX_LEVEL) || (i == acr_pkg::IDX_HOLD) ||
               (i == acr_pkg::IDX_SELFTEST) || (i == acr_pkg::IDX_STORE) || (i == acr_pkg::IDX_SOFTRST);
    endfunction

    // read value of one register; unmapped and write-only bits read zero
    function automatic logic [7:0] read_byte(input logic [7:0] i, input acr_pkg::acr_cfg_t c,
                                             input logic unl, input logic [3:0] rem,
                                             input logic ldg, input logic rdy);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            acr_pkg::IDX_ORIENT: v = c.orient;
            acr_pkg::IDX_LEVEL: v = c.level;
            acr_pkg::IDX_HOLD: v = c.hold;
            acr_pkg::IDX_SELFTEST: v = c.selftest;
            // program bit reads zero, load bit shows reload in progress
            acr_pkg::IDX_STORE: v = {rem, ldg, rdy, 1'b0, unl};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign req = wb_i.cyc & wb_i.stb;
    assign idx = wb_i.adr[9:2];
    assign hold_lim = hold_cycles(s_r.cfg.hold[acr_pkg::HOLD_LSB +: 2]);
    // threshold and upper edge two hysteresis steps above it
    assign thr = {3'b000, s_r.cfg.level[5:0]};
    assign band = thr + {5'b0_0000, s_r.cfg.hold[2:0], 1'b0};

    // next state of the whole register file
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.prog_pls = 1'b0;
        s_nxt.load_pls = 1'b0;
        s_nxt.soft_pls = 1'b0;
        s_nxt.orient_irq = 1'b0;
        s_nxt.level_irq = 1'b0;

        // answer one cycle after the request, data captured with the ack
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack)
        begin
            s_nxt.rdat = {24'h00_0000, read_byte(idx, s_r.cfg, s_r.unlock, nvm_remain, nvm_loading, nvm_ready)};
        end

        // writes take effect on the edge where ack is high; only lane 0 carries data
        if (req && s_r.ack && wb_i.we && wb_i.sel[0])
        begin
            case (idx)
                // enable bit and blocking angle stored here
                acr_pkg::IDX_ORIENT: s_nxt.cfg.orient = wb_i.dat[7:0] & acr_pkg::WMASK_ORIENT;
                acr_pkg::IDX_LEVEL: s_nxt.cfg.level = wb_i.dat[7:0] & acr_pkg::WMASK_LEVEL;
                acr_pkg::IDX_HOLD: s_nxt.cfg.hold = wb_i.dat[7:0] & acr_pkg::WMASK_HOLD;
                acr_pkg::IDX_SELFTEST: s_nxt.cfg.selftest = wb_i.dat[7:0] & acr_pkg::WMASK_SELFTEST;
                acr_pkg::IDX_STORE:
                begin
                    // unlock level kept in the register
                    s_nxt.unlock = wb_i.dat[acr_pkg::UNLOCK_BIT];
                    s_nxt.prog_pls = wb_i.dat[acr_pkg::PROG_BIT];
                    s_nxt.load_pls = wb_i.dat[acr_pkg::LOAD_BIT];
                end
                acr_pkg::IDX_SOFTRST: s_nxt.soft_pls = wb_i.dat[acr_pkg::SOFTRST_BIT];
                default:
                begin
                end
            endcase
        end

        // finished reload overrides every configuration register
        if (nvm_done)
        begin
            s_nxt.cfg = nvm_image;
        end

        // soft reset returns defaults, then the store reload refills them
        if (s_r.soft_pls)
        begin
            s_nxt.cfg = acr_pkg::CFG_DEFAULT;
            s_nxt.unlock = 1'b0;
        end

        // up/down change raises a pulse only when enabled
        s_nxt.ud_prev = updown_i;
        if ((updown_i != s_r.ud_prev) && s_r.cfg.orient[acr_pkg::UD_EN_BIT])
        begin
            s_nxt.orient_irq = 1'b1;
        end

        // enter below the threshold, leave above the band; zero field drops the band entirely
        if (s_r.flat)
        begin
            s_nxt.flat = (s_r.cfg.hold[2:0] == 3'b000) ? ({1'b0, level_measure_i} < thr) :
                         !({1'b0, level_measure_i} > band);
        end
        else
        begin
            s_nxt.flat = ({1'b0, level_measure_i} < thr);
        end

        // report a new flat state once it has held for the hold time
        if (s_nxt.flat != s_r.flat)
        begin
            s_nxt.hold_cnt = 27'h000_0000;
        end
        else if (s_r.flat != s_r.shown)
        begin
            if (s_r.hold_cnt >= hold_lim)
            begin
                s_nxt.shown = s_r.flat;
                s_nxt.level_irq = 1'b1;
                s_nxt.hold_cnt = 27'h000_0000;
            end
            else
            begin
                s_nxt.hold_cnt = s_r.hold_cnt + 27'h000_0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '{acr_pkg::CFG_DEFAULT, 1'b0, 1'b0, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0,
                     27'h000_0000, 1'b0, 1'b0, 1'b0, 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // store controller; it qualifies program and load triggers itself, but a soft reset restarts it even while busy
    acr_store_ctrl u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .soft_i(s_r.soft_pls),
        .load_i(s_r.load_pls),
        .prog_i(s_r.prog_pls),
        .unlock_i(s_r.unlock),
        .cfg_i(s_r.cfg),
        .image_o(nvm_image),
        .load_done_o(nvm_done),
        .ready_o(nvm_ready),
        .loading_o(nvm_loading),
        .remain_o(nvm_remain)
    );

    // bus and detection outputs, all from registers
    assign wb_o.ack = s_r.ack;
    assign wb_o.dat = s_r.rdat;
    assign orient_irq_o = s_r.orient_irq;
    assign level_irq_o = s_r.level_irq;
    assign level_flat_o = s_r.shown;
    assign orient_block_angle_o = s_r.cfg.orient[5:0];
    assign level_angle_o = s_r.cfg.level[5:0];

    // self-test controls straight from the register
    assign st_o.amp_high = s_r.cfg.selftest[acr_pkg::ST_AMP_BIT];
    assign st_o.positive = s_r.cfg.selftest[acr_pkg::ST_SIGN_BIT];
    assign st_o.axis = s_r.cfg.selftest[1:0];
    // all axes valid when idle, else only the axis under test
    assign st_o.valid = (s_r.cfg.selftest[1:0] == 2'b00) ? 3'b111 :
                        3'(3'b001 << (s_r.cfg.selftest[1:0] - 2'b01));

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_bus_ack_drop: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held longer than one cycle");

    a_unmapped_read: assert property (req && !wb_o.ack && !is_mapped(idx) |=> wb_o.dat == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_updown_enabled: assert property (
        $changed(updown_i) && !$past(rst_i) && s_r.cfg.orient[acr_pkg::UD_EN_BIT] |=> orient_irq_o)
        else $error("up/down change lost");

    a_updown_masked: assert property (
        !s_r.cfg.orient[acr_pkg::UD_EN_BIT] |=> !orient_irq_o)
        else $error("masked up/down change raised irq");

    a_hold_wait: assert property (
        level_irq_o |-> $past(s_r.hold_cnt) >= $past(hold_lim))
        else $error("level irq before hold time");

    a_hyst_off: assert property (
        s_r.cfg.hold[2:0] == 3'b000 |-> s_nxt.flat == ({1'b0, level_measure_i} < thr))
        else $error("hysteresis active with zero field");

    a_axis_valid: assert property (
        st_o.axis != 2'b00 |-> $onehot(st_o.valid) && st_o.valid[st_o.axis - 2'b01])
        else $error("self-test valid mask wrong");

    a_ready_read: assert property (
        req && !wb_o.ack && !wb_i.we && idx == acr_pkg::IDX_STORE
        |=> wb_o.dat[acr_pkg::RDY_BIT] == $past(nvm_ready) && !wb_o.dat[acr_pkg::PROG_BIT])
        else $error("store status read wrong");

    a_reload_apply: assert property (
        nvm_done && !s_r.soft_pls |=> s_r.cfg == $past(nvm_image))
        else $error("reload did not refresh registers");

    c_orient_irq: cover property (orient_irq_o);
    c_level_irq: cover property (level_irq_o && hold_lim != 27'h000_0000);
    c_soft_reload: cover property (s_r.soft_pls ##[1:20] nvm_done);
    c_store_write: cover property (s_r.prog_pls && nvm_ready && s_r.unlock);

endmodule

// ===== core/acr_pkg.sv
package acr_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned HOLD_MS_1 = 512;
    localparam int unsigned HOLD_MS_2 = 1024;
    localparam int unsigned HOLD_MS_3 = 2048;
    localparam logic [4:0] NVM_LOAD_CYCLES = 5'h08;
    localparam logic [4:0] NVM_PROG_CYCLES = 5'h10;
    localparam logic [3:0] NVM_WRITES = 4'hF;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_ORIENT = 8'h2D;
    localparam logic [7:0] IDX_LEVEL = 8'h2E;
    localparam logic [7:0] IDX_HOLD = 8'h2F;
    localparam logic [7:0] IDX_SELFTEST = 8'h32;
    localparam logic [7:0] IDX_STORE = 8'h33;
    localparam logic [7:0] IDX_SOFTRST = 8'h3E;

    // reset values and writable bits
    localparam logic [7:0] RST_ORIENT = 8'h48;
    localparam logic [7:0] RST_LEVEL = 8'h08;
    localparam logic [7:0] RST_HOLD = 8'h11;
    localparam logic [7:0] RST_SELFTEST = 8'h00;
    localparam logic [7:0] WMASK_ORIENT = 8'h7F;
    localparam logic [7:0] WMASK_LEVEL = 8'h3F;
    localparam logic [7:0] WMASK_HOLD = 8'h37;
    localparam logic [7:0] WMASK_SELFTEST = 8'h17;

    // field positions
    localparam int unsigned UD_EN_BIT = 6;
    localparam int unsigned HOLD_LSB = 4;
    localparam int unsigned ST_AMP_BIT = 4;
    localparam int unsigned ST_SIGN_BIT = 2;
    localparam int unsigned UNLOCK_BIT = 0;
    localparam int unsigned PROG_BIT = 1;
    localparam int unsigned RDY_BIT = 2;
    localparam int unsigned LOAD_BIT = 3;
    localparam int unsigned REMAIN_LSB = 4;
    localparam int unsigned SOFTRST_BIT = 0;

    // configuration image held in registers and in the store
    typedef struct packed {
        logic [7:0] orient;
        logic [7:0] level;
        logic [7:0] hold;
        logic [7:0] selftest;
    } acr_cfg_t;

    localparam acr_cfg_t CFG_DEFAULT = '{RST_ORIENT, RST_LEVEL, RST_HOLD, RST_SELFTEST};

    // classic wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [9:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } acr_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } acr_wb_rsp_t;

    // self-test controls towards the sensing front end
    typedef struct packed {
        logic amp_high;
        logic positive;
        logic [1:0] axis;
        logic [2:0] valid;
    } acr_st_t;

    typedef enum logic [1:0] {
        NVM_IDLE,
        NVM_LOAD,
        NVM_PROG
    } acr_nvm_state_t;

endpackage

// ===== core/acr_store_ctrl.sv
module acr_store_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // triggers from the register file
    input wire logic soft_i,
    input wire logic load_i,
    input wire logic prog_i,
    input wire logic unlock_i,
    input wire acr_pkg::acr_cfg_t cfg_i,
    // store state
    output acr_pkg::acr_cfg_t image_o,
    output logic load_done_o,
    output logic ready_o,
    output logic loading_o,
    output logic [3:0] remain_o
);

    typedef struct packed {
        acr_pkg::acr_nvm_state_t st;
        logic [4:0] cnt;
        acr_pkg::acr_cfg_t image;
        acr_pkg::acr_cfg_t pend;
        logic [3:0] remain;
        logic done;
    } acr_store_state_t;

    acr_store_state_t s_r;
    acr_store_state_t s_nxt;
    logic accept;

    assign accept = (s_r.st == acr_pkg::NVM_IDLE) && prog_i && unlock_i && (s_r.remain != 4'h0);

    // store sequencer; power-on starts with a load so registers come up from the image
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            acr_pkg::NVM_IDLE:
            begin
                if (accept)
                begin
                    s_nxt.st = acr_pkg::NVM_PROG;
                    s_nxt.cnt = 5'h00;
                    s_nxt.pend = cfg_i;
                    s_nxt.remain = s_r.remain - 4'h1;
                end
                else if (load_i)
                begin
                    s_nxt.st = acr_pkg::NVM_LOAD;
                    s_nxt.cnt = 5'h00;
                end
            end
            acr_pkg::NVM_LOAD:
            begin
                if (s_r.cnt == acr_pkg::NVM_LOAD_CYCLES - 5'h01)
                begin
                    s_nxt.st = acr_pkg::NVM_IDLE;
                    s_nxt.done = 1'b1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                end
            end
            acr_pkg::NVM_PROG:
            begin
                if (s_r.cnt == acr_pkg::NVM_PROG_CYCLES - 5'h01)
                begin
                    s_nxt.st = acr_pkg::NVM_IDLE;
                    s_nxt.image = s_r.pend;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                end
            end
        endcase
        // soft reset restarts a load; a program cut short keeps the old image
        if (soft_i)
        begin
            s_nxt.st = acr_pkg::NVM_LOAD;
            s_nxt.cnt = 5'h00;
        end
    end

    // state register; the image is reset only here, emulating factory contents at power-on
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '{acr_pkg::NVM_LOAD, 5'h00, acr_pkg::CFG_DEFAULT, acr_pkg::CFG_DEFAULT,
                     acr_pkg::NVM_WRITES, 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign ready_o = (s_r.st == acr_pkg::NVM_IDLE);
    assign loading_o = (s_r.st == acr_pkg::NVM_LOAD);
    assign image_o = s_r.image;
    assign load_done_o = s_r.done;
    assign remain_o = s_r.remain;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_remain_decrement: assert property (
        accept && !soft_i |=> remain_o == $past(remain_o) - 4'h1)
        else $error("remaining writes not decremented");

    a_prog_refused: assert property (
        prog_i && (!unlock_i || remain_o == 4'h0) |=> remain_o == $past(remain_o))
        else $error("locked or exhausted program changed counter");

    a_busy_not_ready: assert property (
        accept || (ready_o && load_i) || soft_i |=> !ready_o)
        else $error("ready shown while busy");

    a_load_span: assert property (
        ready_o && load_i && !accept && !soft_i ##1 (!soft_i)[*8] |=> load_done_o)
        else $error("reload did not finish in time");

    a_busy_ignores: assert property (
        !ready_o && prog_i && !soft_i |=> remain_o == $past(remain_o))
        else $error("trigger during busy was taken");

    c_prog_done: cover property (s_r.st == acr_pkg::NVM_PROG ##1 ready_o);

endmodule

// ===== verif/test_acr_cfg_regs.sv
module test_acr_cfg_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and the ports of the block
    logic clk_i;
    logic rst_i;
    acr_pkg::acr_wb_req_t req;
    acr_pkg::acr_wb_rsp_t rsp;
    logic updown;
    logic [7:0] meas;
    logic orient_irq;
    logic level_irq;
    logic level_flat;
    logic [5:0] oang;
    logic [5:0] lang;
    acr_pkg::acr_st_t st;
    int error_cnt;
    int n_checks;
    int n;

    // short millisecond keeps the longest hold at a few thousand cycles
    acr_cfg_regs #(
        .MS_CYCLES(4)
    ) dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_i(req),
        .wb_o(rsp),
        .updown_i(updown),
        .level_measure_i(meas),
        .orient_irq_o(orient_irq),
        .level_irq_o(level_irq),
        .level_flat_o(level_flat),
        .orient_block_angle_o(oang),
        .level_angle_o(lang),
        .st_o(st)
    );

    // free running 40 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we <= w;
        req.adr <= {idx, 2'b00};
        req.sel <= 4'h1;
        req.dat <= {24'h00_0000, wd};
        do
            @(posedge clk_i);
        while (rsp.ack !== 1'b1);
        rd = rsp.dat[7:0];
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        req.we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] t;
        wb(1'b1, idx, v, t);
    endtask

    task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] t;
        wb(1'b0, idx, 8'h00, t);
        chk(nm, t, exp);
    endtask

    task automatic wait_rdy();
        logic [7:0] t;
        do
            wb(1'b0, 8'h33, 8'h00, t);
        while (t[2] !== 1'b1);
    endtask

    // counts edges until the level pulse or the limit
    task automatic wait_lvl(input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk_i);
            cnt++;
        end
        while (level_irq !== 1'b1 && cnt < lim);
    endtask

    // watchdog sized for the longest hold plus bus traffic
    initial
    begin
        #(25 * 20000);
        error_cnt++;
        finish_test();
    end

    // main sequence
    initial
    begin
        error_cnt = 0;
        n_checks = 0;
        rst_i = 1'b1;
        req = '0;
        updown = 1'b0;
        meas = 8'hFF;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc("orient rst", 8'h2D, 8'h48);
        rc("level rst", 8'h2E, 8'h08);
        rc("hold rst", 8'h2F, 8'h11);
        rc("selftest rst", 8'h32, 8'h00);
        wait_rdy();
        rc("store rst", 8'h33, 8'hF4);
        $display("test reset done");

        // writable fields only, reserved and unmapped places read zero
        for (int i = 0; i < 4; i++)
            wr(8'h2D + 8'(i), 8'hFF);
        wr(8'h32, 8'hFF);
        rc("orient mask", 8'h2D, 8'h7F);
        rc("level mask", 8'h2E, 8'h3F);
        rc("hold mask", 8'h2F, 8'h37);
        rc("unmapped", 8'h30, 8'h00);
        rc("selftest mask", 8'h32, 8'h17);
        chk("block angle", oang, 6'h3F);
        chk("level angle", lang, 6'h3F);
        $display("test masks done");

        // every axis code with amplitude and sign varied alongside
        for (int a = 0; a < 4; a++)
        begin
            wr(8'h32, {3'b000, a[0], 1'b0, a[1], a[1:0]});
            repeat (50 * 4) @(posedge clk_i);
            chk("st axis", st.axis, a[1:0]);
            chk("st amp", st.amp_high, a[0]);
            chk("st sign", st.positive, a[1]);
            chk("st valid", st.valid, (a == 0) ? 3'b111 : 3'(1 << (a - 1)));
        end
        $display("test selftest done");

        // up/down change raises a pulse only while enabled
        for (int e = 1; e >= 0; e--)
        begin
            wr(8'h2D, {1'b0, e[0], 6'h00});
            updown <= ~updown;
            @(posedge clk_i);
            @(posedge clk_i);
            chk("orient irq", orient_irq, e[0]);
        end
        $display("test orientation done");

        // flat entry with no hold, exit only beyond twice the hysteresis
        wr(8'h2E, 8'h10);
        wr(8'h2F, 8'h00);
        meas <= 8'h05;
        wait_lvl(8, n);
        chk("flat fast", n <= 5, 1'b1);
        chk("flat on", level_flat, 1'b1);
        wr(8'h2F, 8'h02);
        meas <= 8'h14;
        wait_lvl(8, n);
        chk("hyst hold", n, 8);
        meas <= 8'h15;
        wait_lvl(8, n);
        chk("flat off", level_flat, 1'b0);
        wr(8'h2F, 8'h00);
        meas <= 8'h05;
        wait_lvl(8, n);
        meas <= 8'h11;
        wait_lvl(8, n);
        chk("no hyst off", level_flat, 1'b0);
        wr(8'h2F, 8'h10);
        meas <= 8'h05;
        wait_lvl(2100, n);
        chk("hold 512", (n >= 2048) && (n <= 2060), 1'b1);
        meas <= 8'hFF;
        wait_lvl(2100, n);
        $display("test level done");

        // locked program is ignored, unlocked one spends one write
        wr(8'h33, 8'h02);
        wait_rdy();
        rc("locked", 8'h33, 8'hF4);
        wr(8'h2D, 8'h55);
        wr(8'h2E, 8'h2A);
        wr(8'h2F, 8'h23);
        wr(8'h32, 8'h16);
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h03);
        rc("prog busy", 8'h33, 8'hE1);
        wr(8'h33, 8'h03);
        wait_rdy();
        rc("prog once", 8'h33, 8'hE5);
        wr(8'h2D, 8'h00);
        wr(8'h32, 8'h00);
        wr(8'h33, 8'h09);
        rc("load busy", 8'h33, 8'hE9);
        wait_rdy();
        rc("load orient", 8'h2D, 8'h55);
        rc("load level", 8'h2E, 8'h2A);
        rc("load hold", 8'h2F, 8'h23);
        rc("load st", 8'h32, 8'h16);
        rc("load clear", 8'h33, 8'hE5);
        $display("test store done");

        // soft reset brings the stored image back and locks
        wr(8'h2D, 8'h00);
        wr(8'h3E, 8'h01);
        wait_rdy();
        rc("soft orient", 8'h2D, 8'h55);
        rc("soft store", 8'h33, 8'hE4);
        $display("test soft reset done");
        finish_test();
    end
endmodule
